// *** ksc_pkg.sv ***
/*
 keypad scan control: shared constants, state encodings and carriers.
 assumes a 25 MHz pclk and an APB master with 32-bit data.
*/
`default_nettype none
package ksc_pkg;
   // ==========================================
   // matrix and clocking
   localparam int COLS = 5;
   localparam int ROWS = 6;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // ==========================================
   // register indices; byte address is index times four
   localparam logic [7:0] IDX_COLUMN = 8'hd1;
   localparam logic [7:0] IDX_ROW    = 8'hd2;
   localparam logic [7:0] IDX_TIMING = 8'hd3;
   localparam logic [7:0] IDX_STATUS = 8'hd4;
   localparam logic [7:0] IDX_SIZE   = 8'hd5;
   localparam logic [9:0] ADDR_COLUMN = {IDX_COLUMN, 2'h0};
   localparam logic [9:0] ADDR_ROW    = {IDX_ROW, 2'h0};
   localparam logic [9:0] ADDR_TIMING = {IDX_TIMING, 2'h0};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
   localparam logic [9:0] ADDR_SIZE   = {IDX_SIZE, 2'h0};
   // ==========================================
   // reset values
   localparam logic [4:0] RST_COLUMN = 5'h1f;
   localparam logic [5:0] RST_ROW    = 6'h3f;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [5:0] RST_SIZE   = 6'h00;
   // ==========================================
   // field layout
   localparam int ST_IRQ_ON = 0;
   localparam int ST_FLAG   = 1;
   localparam int ST_AUTO   = 2;
   localparam int ST_CLK    = 3;
   localparam int DB_LSB    = 2;
   localparam int DB_W      = 6;
   localparam int PR_W      = 2;
   localparam int SZ_W      = 3;
   localparam int SZ_ROW_LSB = 3;
   localparam int DB_UNIT_MS = 4;
   localparam logic [2:0] PROBE_ZERO_MS = 3'h4;
   // ==========================================
   // state
   typedef enum logic [2:0] {
      PH_IDLE, PH_DEB_PRESS, PH_SCAN, PH_WAIT_REL, PH_DEB_REL
   } ksc_phase_t;

   typedef struct packed {
      ksc_phase_t  phase;
      logic [4:0]  col_reg;
      logic [5:0]  row_reg;
      logic [7:0]  timing;
      logic        irq_on;
      logic        flag;
      logic        auto_scan_on;
      logic [5:0]  size;
      logic [8:0]  ms_cnt;
      logic [2:0]  col_idx;
      logic [2:0]  row_idx;
      logic [1:0]  hits;
      logic [2:0]  hit_col;
      logic [2:0]  hit_row;
      logic [5:0]  rows_prev;
      logic [4:0]  col_out;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ksc_state_t;
endpackage : ksc_pkg
`default_nettype wire

// *** ksc_ms_tick.sv ***
/*
 millisecond tick and 1 kHz keypad clock level from pclk.
 assumes run is the keypad clock enable; counting freezes while it is low.
*/
`default_nettype none
module ksc_ms_tick #(
   parameter int CYCLES = 25000
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic run,
   // outputs
   output logic      tick,
   output logic      level
);
   localparam int W = $clog2(CYCLES);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   localparam logic [W-1:0] HALF = W'(CYCLES / 2 - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         level;
      logic         tick;
   } ksc_tick_t;

   ksc_tick_t s, next_s;

   if (CYCLES < 2) begin : g_bad
      $error("ksc_ms_tick: CYCLES must be at least 2");
   end

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (run) begin
         next_s.cnt = (s.cnt == LAST) ? '0 : s.cnt + 1'b1;
         next_s.tick = (s.cnt == LAST);
         if (s.cnt == HALF || s.cnt == LAST) begin
            next_s.level = ~s.level;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
   assign level = s.level;
endmodule : ksc_ms_tick
`default_nettype wire

// *** ksc_keypad_scan.sv ***
/*
 keypad scan control: APB registers, auto scan engine, bypass edge detect.
 assumes row inputs synchronous to pclk, pulled high when idle.
*/
// Local design decision: the APB register port.
//Contract
//RULE1: debounce field counts 4 ms, zero means 256
//RULE2: debounce both press and release
//RULE3: probe field sets ms between key checks
//RULE4: probe code 3 is 3 ms, 0 is 4
//RULE5: auto scan bit runs hardware scanning
//RULE6: bypass: firmware scans by columns and rows
//RULE7: valid auto key sets flag and interrupt
//RULE8: bypass: row falling edge from all-high sets flag
//RULE9: status read clears key found flag
//RULE10: bypass flag works without keypad clock
//RULE11: irq enable gates interrupt, not flag
//RULE12: status bit 3 shows keypad clock level
//RULE13: matrix size ignored in bypass mode
//RULE14: idle auto: all columns low, debounce press
//RULE15: one column low, single key only valid
//RULE16: debounce release, restart if still pressed
//RULE17: bypass drives columns from column register
`default_nettype none
module ksc_keypad_scan #(
   parameter int MS_CYCLES = ksc_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // keypad
   input  wire logic        kbd_clk_en,
   input  wire logic [5:0]  row_in,
   output logic [4:0]       col_out,
   // interrupt
   output logic             irq
);
   ksc_pkg::ksc_state_t s, next_s;
   logic tick;
   logic clk_level;

   if (MS_CYCLES < 2) begin : g_bad
      $error("ksc_keypad_scan: MS_CYCLES too small");
   end

   ksc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (kbd_clk_en),
      .tick    (tick),
      .level   (clk_level)
   );

   // ==========================================
   // derived settings
   logic [5:0] db_field;
   logic [8:0] db_ms;
   logic [2:0] probe_ms;
   logic [2:0] cols_n;
   logic [2:0] rows_n;
   logic       any_low;

   always_comb begin
      db_field = s.timing[ksc_pkg::DB_LSB +: ksc_pkg::DB_W];
      db_ms = 9'({(db_field == '0), db_field} * ksc_pkg::DB_UNIT_MS); //RULE1
      probe_ms = (s.timing[ksc_pkg::PR_W-1:0] == '0) ?
                 ksc_pkg::PROBE_ZERO_MS : {1'b0, s.timing[ksc_pkg::PR_W-1:0]}; //RULE3 RULE4
      cols_n = s.size[ksc_pkg::SZ_W-1:0];
      rows_n = s.size[ksc_pkg::SZ_ROW_LSB +: ksc_pkg::SZ_W];
      // zero or oversize falls back to the full matrix
      if (cols_n == '0 || cols_n > 3'(ksc_pkg::COLS)) cols_n = 3'(ksc_pkg::COLS);
      if (rows_n == '0 || rows_n > 3'(ksc_pkg::ROWS)) rows_n = 3'(ksc_pkg::ROWS);
      any_low = ~&row_in;
   end

   // ==========================================
   // next state
   logic setup;
   logic acc;
   logic rd_clear;
   logic set_flag;
   logic valid_done;
   logic [1:0] h;
   logic [2:0] hc;
   logic [2:0] hr;

   always_comb begin
      next_s = s;
      set_flag = 1'b0;
      valid_done = 1'b0;
      h = s.hits;
      hc = s.hit_col;
      hr = s.hit_row;
      setup = psel & ~penable;
      acc = psel & penable & s.pready;
      next_s.pready = setup;
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      next_s.rows_prev = row_in;
      rd_clear = acc & ~pwrite & (paddr[9:0] == ksc_pkg::ADDR_STATUS) &
                 s.prdata[ksc_pkg::ST_FLAG];

      // read data is latched at setup and presented in the access phase
      if (setup && !pwrite) begin
         unique case (paddr[9:0])
            ksc_pkg::ADDR_COLUMN: next_s.prdata = {27'h0, s.col_reg};
            ksc_pkg::ADDR_ROW:
               next_s.prdata = {26'h0, s.auto_scan_on ? s.row_reg : row_in};
            ksc_pkg::ADDR_TIMING: next_s.prdata = {24'h0, s.timing};
            ksc_pkg::ADDR_STATUS: begin
               next_s.prdata[ksc_pkg::ST_CLK] = clk_level; //RULE12
               next_s.prdata[ksc_pkg::ST_AUTO] = s.auto_scan_on;
               next_s.prdata[ksc_pkg::ST_FLAG] = s.flag;
               next_s.prdata[ksc_pkg::ST_IRQ_ON] = s.irq_on;
            end
            ksc_pkg::ADDR_SIZE: next_s.prdata = {26'h0, s.size};
            default: next_s.pslverr = 1'b1;
         endcase
      end
      if (setup && pwrite) begin
         next_s.pslverr = !(paddr[9:0] inside {ksc_pkg::ADDR_COLUMN,
            ksc_pkg::ADDR_ROW, ksc_pkg::ADDR_TIMING, ksc_pkg::ADDR_STATUS,
            ksc_pkg::ADDR_SIZE});
      end

      if (acc && pwrite) begin
         unique case (paddr[9:0])
            ksc_pkg::ADDR_COLUMN: begin
               // hardware owns the column register while scanning
               if (!s.auto_scan_on) next_s.col_reg = pwdata[4:0]; //RULE6
            end
            ksc_pkg::ADDR_TIMING: next_s.timing = pwdata[7:0];
            ksc_pkg::ADDR_STATUS: begin
               next_s.irq_on = pwdata[ksc_pkg::ST_IRQ_ON];
               next_s.auto_scan_on = pwdata[ksc_pkg::ST_AUTO];
            end
            ksc_pkg::ADDR_SIZE: next_s.size = pwdata[5:0];
            default: ;
         endcase
      end

      // bypass: no keypad clock needed, runs on pclk
      if (!s.auto_scan_on && (&s.rows_prev) && any_low) begin
         set_flag = 1'b1; //RULE8 RULE10
      end

      // ==========================================
      // auto scan engine
      if (!s.auto_scan_on) begin
         next_s.phase = ksc_pkg::PH_IDLE;
         next_s.ms_cnt = '0;
      end else begin
         unique case (s.phase) //RULE5 RULE13
            ksc_pkg::PH_IDLE: begin
               next_s.ms_cnt = '0;
               if (any_low) next_s.phase = ksc_pkg::PH_DEB_PRESS; //RULE14
            end
            ksc_pkg::PH_DEB_PRESS: begin
               if (tick) begin
                  next_s.ms_cnt = s.ms_cnt + 1'b1;
                  if (s.ms_cnt + 1'b1 == db_ms) begin //RULE2
                     next_s.ms_cnt = '0;
                     next_s.col_idx = '0;
                     next_s.row_idx = '0;
                     next_s.hits = '0;
                     next_s.phase = any_low ? ksc_pkg::PH_SCAN
                                            : ksc_pkg::PH_IDLE; //RULE14
                  end
               end
            end
            ksc_pkg::PH_SCAN: begin
               if (tick) begin
                  next_s.ms_cnt = s.ms_cnt + 1'b1;
                  if (s.ms_cnt + 1'b1 == 9'(probe_ms)) begin //RULE3
                     next_s.ms_cnt = '0;
                     if (!row_in[s.row_idx]) begin
                        h = (s.hits == 2'h2) ? s.hits : s.hits + 1'b1;
                        hc = s.col_idx;
                        hr = s.row_idx;
                     end
                     next_s.hits = h;
                     next_s.hit_col = hc;
                     next_s.hit_row = hr;
                     next_s.row_idx = s.row_idx + 1'b1;
                     if (s.row_idx == rows_n - 1'b1) begin
                        next_s.row_idx = '0;
                        next_s.col_idx = s.col_idx + 1'b1;
                        if (s.col_idx == cols_n - 1'b1) begin
                           next_s.phase = ksc_pkg::PH_WAIT_REL;
                           if (h == 2'h1) begin //RULE15
                              valid_done = 1'b1;
                              next_s.col_reg = ~(5'h01 << hc); //RULE7
                              next_s.row_reg = ~(6'h01 << hr);
                              set_flag = 1'b1; //RULE7
                           end
                        end
                     end
                  end
               end
            end
            ksc_pkg::PH_WAIT_REL: begin
               next_s.ms_cnt = '0;
               if (!any_low) next_s.phase = ksc_pkg::PH_DEB_REL; //RULE16
            end
            ksc_pkg::PH_DEB_REL: begin
               if (tick) begin
                  next_s.ms_cnt = s.ms_cnt + 1'b1;
                  if (s.ms_cnt + 1'b1 == db_ms) begin //RULE2
                     next_s.ms_cnt = '0;
                     if (!any_low) next_s.phase = ksc_pkg::PH_IDLE; //RULE16
                  end
               end
            end
            default: next_s.phase = ksc_pkg::PH_IDLE;
         endcase
      end

      // set wins over the read clear
      if (rd_clear) next_s.flag = 1'b0; //RULE9
      if (set_flag) next_s.flag = 1'b1;
      next_s.irq = next_s.flag & next_s.irq_on; //RULE11

      if (!next_s.auto_scan_on) begin
         next_s.col_out = next_s.col_reg; //RULE17
      end else if (next_s.phase == ksc_pkg::PH_SCAN) begin
         next_s.col_out = ~(5'h01 << next_s.col_idx); //RULE15
      end else begin
         next_s.col_out = '0; //RULE14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.phase <= ksc_pkg::PH_IDLE;
         s.col_reg <= ksc_pkg::RST_COLUMN;
         s.row_reg <= ksc_pkg::RST_ROW;
         s.timing <= ksc_pkg::RST_TIMING;
         s.size <= ksc_pkg::RST_SIZE;
         s.rows_prev <= ksc_pkg::RST_ROW;
         s.col_out <= ksc_pkg::RST_COLUMN;
      end else begin
         s <= next_s;
      end
   end

   assign pready = s.pready;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr;
   assign col_out = s.col_out;
   assign irq = s.irq;

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_press_debounce: assert property ( //RULE1
      s.phase == ksc_pkg::PH_DEB_PRESS && next_s.phase == ksc_pkg::PH_SCAN
      |-> tick && s.ms_cnt + 1'b1 == db_ms)
      else $error("press debounce ended at wrong count");
   a_release_debounce: assert property ( //RULE2
      s.phase == ksc_pkg::PH_DEB_REL && next_s.phase == ksc_pkg::PH_IDLE
      |-> tick && s.ms_cnt + 1'b1 == db_ms && !any_low)
      else $error("release debounce ended early");
   a_probe_step: assert property ( //RULE3
      s.auto_scan_on && s.phase == ksc_pkg::PH_SCAN
      |-> s.ms_cnt < 9'(probe_ms))
      else $error("probe interval exceeded");
   a_valid_flag: assert property ( //RULE7
      valid_done |=> s.flag ##0 (s.irq == s.irq_on))
      else $error("valid key did not set flag");
   a_bypass_edge: assert property ( //RULE8
      !s.auto_scan_on && (&s.rows_prev) && any_low |=> s.flag)
      else $error("bypass row edge missed");
   a_read_clears: assert property ( //RULE9
      rd_clear && !set_flag |=> !s.flag)
      else $error("status read did not clear flag");
   a_irq_gate: assert property ( //RULE11
      s.irq == (s.flag && s.irq_on))
      else $error("interrupt not gated by enable");
   a_clock_bit: assert property ( //RULE12
      psel && !penable && !pwrite && paddr[9:0] == ksc_pkg::ADDR_STATUS
      |=> s.prdata[ksc_pkg::ST_CLK] == $past(clk_level))
      else $error("clock level bit wrong");
   a_idle_cols_low: assert property ( //RULE14
      s.auto_scan_on && s.phase == ksc_pkg::PH_IDLE |-> s.col_out == '0)
      else $error("idle columns not low");
   a_one_col_low: assert property ( //RULE15
      s.auto_scan_on && s.phase == ksc_pkg::PH_SCAN |-> $onehot(~s.col_out))
      else $error("more than one column driven in scan");
   a_bypass_cols: assert property ( //RULE17
      !s.auto_scan_on |-> s.col_out == s.col_reg)
      else $error("bypass columns differ from register");
endmodule : ksc_keypad_scan
`default_nettype wire

// *** ksc_keypad_model.sv ***
/*
 switch matrix model standing at the keypad pins of the scan block.
 assumes keys[c*6+r] closes column c onto row r; rows are pulled high.
*/
`default_nettype none
module ksc_keypad_model (
   // columns and switches
   input  wire logic [4:0]  col_out,
   input  wire logic [29:0] keys,
   // rows
   output logic [5:0]       row_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // open rows fall to the pull-up, never keep the last value
   always_comb begin
      row_in = 6'h3f;
      for (int c = 0; c < 5; c++) begin
         for (int r = 0; r < 6; r++) begin
            if (keys[c*6+r] && !col_out[c]) begin
               row_in[r] = 1'b0;
            end
         end
      end
   end
endmodule : ksc_keypad_model
`default_nettype wire

// *** testbench.sv ***
/*
 self-checking bench for the keypad scan block over apb.
 assumes zero wait-state apb answers and the matrix model on the pins.
*/
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MSC = 8;
   logic        pclk, presetn, psel, penable, pwrite, kbd_clk_en;
   logic        pready, pslverr, irq, err, s0, s1;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0]  col_out;
   logic [5:0]  row_in;
   logic [29:0] keys;
   int          bad_count, n_compared, cnt, dm, pm, ex;
   int          db[5] = '{1, 0, 2, 1, 1};
   int          pr[5] = '{1, 1, 3, 0, 2};
   // ==========================================
   // instances
   ksc_keypad_scan #(.MS_CYCLES(MSC)) ksc_keypad_scan_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .kbd_clk_en(kbd_clk_en),
      .row_in(row_in), .col_out(col_out), .irq(irq));
   ksc_keypad_model ksc_keypad_model_inst (
      .col_out(col_out), .keys(keys), .row_in(row_in));
   // ==========================================
   // tasks
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic press(input logic [29:0] k);
      @(posedge pclk);
      keys <= k;
   endtask : press
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // ==========================================
   // clock, reset, watchdog
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #1600000;
      bad_count++;
      summarize();
   end
   // ==========================================
   // tests
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, kbd_clk_en} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      keys = 30'h0;
      bad_count = 0;
      n_compared = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ksc_pkg::ADDR_COLUMN, 0); `CHK(q, 32'h1f)
      apb(0, ksc_pkg::ADDR_ROW, 0); `CHK(q, 32'h3f)
      apb(0, ksc_pkg::ADDR_TIMING, 0); `CHK(q, 32'h0)
      apb(0, ksc_pkg::ADDR_STATUS, 0); `CHK(q, 32'h0)
      apb(0, ksc_pkg::ADDR_SIZE, 0); `CHK(q, 32'h0)
      apb(0, 10'h3fc, 0); `CHK({err, q}, 33'h100000000)
      $display("test reset done");
      // bypass with the keypad clock stopped
      apb(1, ksc_pkg::ADDR_COLUMN, 32'h1e);
      apb(1, ksc_pkg::ADDR_SIZE, 32'h09);
      `CHK(col_out, 5'h1e)
      press(30'h1);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(0, ksc_pkg::ADDR_ROW, 0); `CHK(q, 32'h3e)
      apb(0, ksc_pkg::ADDR_STATUS, 0); `CHK(q[1], 1'b1)
      apb(0, ksc_pkg::ADDR_STATUS, 0); `CHK(q[1], 1'b0)
      press(30'h0);
      apb(1, ksc_pkg::ADDR_STATUS, 32'h01);
      press(30'h4);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(0, ksc_pkg::ADDR_STATUS, 0);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      press(30'h0);
      $display("test bypass done");
      // keypad clock level seen in the status word
      kbd_clk_en <= 1'b1;
      {s0, s1} = 2'b00;
      repeat (6) begin
         apb(0, ksc_pkg::ADDR_STATUS, 0);
         s1 |= q[3];
         s0 |= ~q[3];
      end
      `CHK({s0, s1}, 2'b11)
      $display("test clock done");
      // automatic scanning over every probe code and debounce zero
      apb(0, ksc_pkg::ADDR_SIZE, 0); `CHK(q, 32'h09)
      // back to the full matrix, or the scan would only probe column 0 row 0
      apb(1, ksc_pkg::ADDR_SIZE, 0);
      apb(1, ksc_pkg::ADDR_STATUS, 32'h05);
      repeat (3) @(posedge pclk);
      `CHK(col_out, 5'h00)
      for (int i = 0; i < 5; i++) begin
         dm = (db[i] == 0) ? 64 : db[i];
         pm = (pr[i] == 0) ? 4 : pr[i];
         ex = (dm * 4 + 30 * pm) * MSC;
         apb(1, ksc_pkg::ADDR_TIMING, {24'h0, 6'(db[i]), 2'(pr[i])});
         press(30'h1 << (i * 6 + i + 1));
         cnt = 0;
         while (irq !== 1'b1 && cnt < 9000) begin
            @(posedge pclk);
            cnt++;
         end
         `CHK(cnt >= ex - pm * MSC - 24 && cnt <= ex + 24, 1'b1)
         apb(0, ksc_pkg::ADDR_COLUMN, 0); `CHK(q, {27'h0, ~(5'h1 << i)})
         apb(0, ksc_pkg::ADDR_ROW, 0); `CHK(q, {26'h0, ~(6'h1 << (i + 1))})
         apb(0, ksc_pkg::ADDR_STATUS, 0); `CHK(q[2:0], 3'h7)
         repeat (2) @(posedge pclk);
         `CHK(irq, 1'b0)
         press(30'h0);
         repeat (dm * 4 * MSC + 64) @(posedge pclk);
         `CHK(col_out, 5'h00)
      end
      $display("test auto done");
      // two keys at once are never reported
      press(30'h1 << 7 | 30'h1 << 22);
      repeat (800) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(0, ksc_pkg::ADDR_STATUS, 0); `CHK(q[1], 1'b0)
      press(30'h0);
      repeat (200) @(posedge pclk);
      $display("test double done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
